// *** core/vicr_cfg.svh ***
// offsets, field positions and reset values of the video input config bank
`ifndef VICR_CFG_SVH
`define VICR_CFG_SVH
// register indices, byte address is four times the index
`define VICR_IDX_INPUT_SOURCE_SELECT     8'h21
`define VICR_IDX_PICSTART  8'h22
`define VICR_IDX_LDELAY    8'h23
`define VICR_IDX_HELPER    8'h29
`define VICR_IDX_VGA       8'h2f
`define VICR_IDX_IRQ_STAT  8'h30
`define VICR_IDX_IRQ_MASK  8'h31
// input source select fields
`define VICR_LUMA_MSB      1
`define VICR_LUMA_LSB      0
`define VICR_CHROMA_BIT    2
`define VICR_IFC_MSB       4
`define VICR_IFC_LSB       3
`define VICR_CBW_MSB       6
`define VICR_CBW_LSB       5
`define VICR_NOTCH_BIT     7
`define VICR_LUMA_LOWPASS_BIT_BIT      8
`define VICR_PLL_MSB       10
`define VICR_PLL_LSB       9
`define VICR_DONE_BIT      11
// delay and vga fields
`define VICR_LUMA_CHROMA_DELAY_MSB      11
`define VICR_LUMA_CHROMA_DELAY_LSB      6
`define VICR_VGA_FREQ_MSB  1
`define VICR_VGA_FREQ_LSB  0
`define VICR_VGA_EN_BIT    2
// reset values
`define VICR_RST_INPUT_SOURCE_SELECT     12'h644
`define VICR_RST_PICSTART  12'h000
`define VICR_RST_ZERO      12'h000
`define VICR_HLP_LIMIT     12'h060
`define VICR_IFC_SECAM     2'h3
`endif

// *** core/vicr_pkg.sv ***
// types shared by the video input config bank
package vicr_pkg;
    typedef logic [11:0] vicr_word_t;
    typedef enum logic [1:0] {
        VICR_PLL_KEEP,
        VICR_PLL_TERR,
        VICR_PLL_VCR,
        VICR_PLL_MIXED
    } vicr_pll_speed_t;
    typedef enum logic [1:0] {
        VICR_BW_NARROW,
        VICR_BW_NORMAL,
        VICR_BW_BROAD,
        VICR_BW_WIDE
    } vicr_chroma_bw_t;
endpackage

// *** core/vicr_regs.sv ***
// control register bank of the video input path with avalon-mm slave
//
// Behaviour
// - writing input source select also pulses a re-init of the current standard.
// - luma source code 00/01/10/11 routes input three/two/one/four, default 00.
// - chroma source bit picks input one when clear and chroma input when set, default set.
// - if compensation code picks off, 6 dB/oct, 12 dB/oct, 10 dB/MHz, the last for secam only.
// - chroma bandwidth codes 0..3 are narrow, normal, broad, wide, default broad.
// - one bit picks adaptive or fixed secam notch, another enables luma lowpass, both default clear.
// - pll speed codes are keep, terrestrial, vcr, mixed, default mixed.
// - bit 11 of input select and vga control is written zero and set by the processor on completion.
// - a new picture start value takes effect only on standard update, input source select write or scaler mode write.
// - luma delay sits in the upper six bits, applied on standard update, lower six bits zero.
// - helper delay applies only in helper mode and shifts over a signed span of about 96 units.
// - vga line frequency code 0/1/2-3 picks 31.5/35.2/37.9 kHz with 2 percent pull-in.
// - while vga mode is disabled the line frequency field is forced to zero.
// - on reset every field takes its default value.
`timescale 1ns/10ps
`default_nettype none
`include "vicr_cfg.svh"

module vicr_regs
    import vicr_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // avalon-mm slave, byte address
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // processor side events
    input  wire logic        std_update,
    input  wire logic        scaler_mode_wr,
    input  wire logic        input_source_select_done,
    input  wire logic        vga_done,
    input  wire logic        std_is_secam,
    input  wire logic        helper_mode,
    // decoded controls
    output logic             std_reinit,
    output logic [3:0]       luma_input_sel,
    output logic             chroma_from_cin,
    output logic [1:0]       if_comp_mode,
    output vicr_chroma_bw_t  chroma_bw,
    output logic             fixed_notch,
    output logic             luma_lowpass_en,
    output vicr_pll_speed_t  line_pll_speed,
    output logic [11:0]      picture_start,
    output logic [5:0]       luma_delay,
    output logic [11:0]      helper_delay,
    output logic [2:0]       vga_line_freq_sel,
    output logic             pc_mode_en,
    // interrupt
    output logic             irq
);

    // ****************************************
    // bus slave
    // ****************************************
    logic       ack_ff;
    logic       req;
    logic       wr_take;
    logic [7:0] idx;

    assign req             = avs_read | avs_write;
    assign idx             = avs_address[9:2];
    // one wait cycle gives the read mux a full clock
    assign avs_waitrequest = req & ~ack_ff;
    assign wr_take         = avs_write & ack_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    function automatic logic is_wr(input logic [7:0] i, input logic [7:0] r);
        is_wr = (i == r);
    endfunction

    logic wr_input_source_select;
    logic wr_pic;
    logic wr_luma_chroma_delay;
    logic wr_hlp;
    logic wr_vga;
    logic wr_stat;
    logic wr_mask;

    assign wr_input_source_select = wr_take & is_wr(idx, `VICR_IDX_INPUT_SOURCE_SELECT);
    assign wr_pic   = wr_take & is_wr(idx, `VICR_IDX_PICSTART);
    assign wr_luma_chroma_delay  = wr_take & is_wr(idx, `VICR_IDX_LDELAY);
    assign wr_hlp   = wr_take & is_wr(idx, `VICR_IDX_HELPER);
    assign wr_vga   = wr_take & is_wr(idx, `VICR_IDX_VGA);
    assign wr_stat  = wr_take & is_wr(idx, `VICR_IDX_IRQ_STAT);
    assign wr_mask  = wr_take & is_wr(idx, `VICR_IDX_IRQ_MASK);

    // ****************************************
    // input source select
    // ****************************************
    vicr_word_t input_source_select_ff;
    vicr_word_t wdata;

    assign wdata = avs_writedata[11:0];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            input_source_select_ff <= `VICR_RST_INPUT_SOURCE_SELECT;
        end else begin
            if (wr_input_source_select) begin
                input_source_select_ff <= wdata;
            end
            // completion set wins over the software zero
            if (input_source_select_done) begin
                input_source_select_ff[`VICR_DONE_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            std_reinit <= 1'b0;
        end else begin
            std_reinit <= wr_input_source_select;
        end
    end

    logic [1:0] luma_code;
    logic [1:0] ifc_code;

    assign luma_code = input_source_select_ff[`VICR_LUMA_MSB:`VICR_LUMA_LSB];
    assign ifc_code  = input_source_select_ff[`VICR_IFC_MSB:`VICR_IFC_LSB];

    // one-hot order: input one, two, three, four
    always_comb begin
        unique case (luma_code)
            2'h0: luma_input_sel = 4'h4;
            2'h1: luma_input_sel = 4'h2;
            2'h2: luma_input_sel = 4'h1;
            2'h3: luma_input_sel = 4'h8;
        endcase
    end

    assign chroma_from_cin = input_source_select_ff[`VICR_CHROMA_BIT];
    // the per-mhz boost would distort pal/ntsc, so it falls back to off
    assign if_comp_mode    = (ifc_code == `VICR_IFC_SECAM && !std_is_secam)
                             ? 2'h0 : ifc_code;
    assign chroma_bw       = vicr_chroma_bw_t'(
                             input_source_select_ff[`VICR_CBW_MSB:`VICR_CBW_LSB]);
    assign fixed_notch     = input_source_select_ff[`VICR_NOTCH_BIT];
    assign luma_lowpass_en = input_source_select_ff[`VICR_LUMA_LOWPASS_BIT_BIT];
    assign line_pll_speed  = vicr_pll_speed_t'(
                             input_source_select_ff[`VICR_PLL_MSB:`VICR_PLL_LSB]);

    // ****************************************
    // picture start and luma delay
    // ****************************************
    vicr_word_t pic_ff;
    vicr_word_t pic_act_ff;
    logic [5:0] luma_chroma_delay_ff;
    logic [5:0] luma_chroma_delay_act_ff;
    logic       std_apply;
    logic       pic_apply;

    // an input select write re-inits the standard just as a standard write
    assign std_apply = std_update | wr_input_source_select;
    assign pic_apply = std_apply | scaler_mode_wr;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pic_ff <= `VICR_RST_PICSTART;
        end else if (wr_pic) begin
            pic_ff <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pic_act_ff <= `VICR_RST_PICSTART;
        end else if (pic_apply) begin
            pic_act_ff <= pic_ff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            luma_chroma_delay_ff <= 6'h00;
        end else if (wr_luma_chroma_delay) begin
            luma_chroma_delay_ff <= wdata[`VICR_LUMA_CHROMA_DELAY_MSB:`VICR_LUMA_CHROMA_DELAY_LSB];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            luma_chroma_delay_act_ff <= 6'h00;
        end else if (std_apply) begin
            luma_chroma_delay_act_ff <= luma_chroma_delay_ff;
        end
    end

    assign picture_start = pic_act_ff;
    assign luma_delay    = luma_chroma_delay_act_ff;

    // ****************************************
    // helper line delay
    // ****************************************
    vicr_word_t hlp_ff;
    vicr_word_t hlp_clamp;
    logic       hlp_neg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hlp_ff <= `VICR_RST_ZERO;
        end else if (wr_hlp) begin
            hlp_ff <= wdata;
        end
    end

    // limited span, out of range values saturate instead of wrapping
    assign hlp_neg = hlp_ff[11];
    always_comb begin
        hlp_clamp = hlp_ff;
        if (!hlp_neg && hlp_ff > `VICR_HLP_LIMIT) begin
            hlp_clamp = `VICR_HLP_LIMIT;
        end else if (hlp_neg && (12'h000 - hlp_ff) > `VICR_HLP_LIMIT) begin
            hlp_clamp = 12'h000 - `VICR_HLP_LIMIT;
        end
    end

    assign helper_delay = helper_mode ? hlp_clamp : 12'h000;

    // ****************************************
    // vga mode
    // ****************************************
    vicr_word_t vga_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vga_ff <= `VICR_RST_ZERO;
        end else begin
            if (wr_vga) begin
                vga_ff <= wdata;
            end
            // look at the enable being written, so an enabling write keeps
            // its frequency code instead of losing it to the force
            if (wr_vga ? !wdata[`VICR_VGA_EN_BIT]
                       : !vga_ff[`VICR_VGA_EN_BIT]) begin
                vga_ff[`VICR_VGA_FREQ_MSB:`VICR_VGA_FREQ_LSB] <= 2'h0;
            end
            if (vga_done) begin
                vga_ff[`VICR_DONE_BIT] <= 1'b1;
            end
        end
    end

    assign pc_mode_en = vga_ff[`VICR_VGA_EN_BIT];

    // one-hot: 31.5, 35.2, 37.9 khz; pll pulls in 2 percent around it
    always_comb begin
        unique case (vga_ff[`VICR_VGA_FREQ_MSB:`VICR_VGA_FREQ_LSB])
            2'h0:    vga_line_freq_sel = 3'h1;
            2'h1:    vga_line_freq_sel = 3'h2;
            default: vga_line_freq_sel = 3'h4;
        endcase
    end

    // ****************************************
    // interrupts
    // ****************************************
    logic [1:0] stat_ff;
    logic [1:0] mask_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stat_ff <= 2'h0;
        end else begin
            stat_ff <= (stat_ff & ~(wr_stat ? avs_writedata[1:0] : 2'h0))
                       | {vga_done, input_source_select_done};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mask_ff <= 2'h0;
        end else if (wr_mask) begin
            mask_ff <= avs_writedata[1:0];
        end
    end

    assign irq = |(stat_ff & mask_ff);

    // ****************************************
    // read data
    // ****************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        unique case (idx)
            `VICR_IDX_INPUT_SOURCE_SELECT:    rd_mux = {20'h0, input_source_select_ff};
            `VICR_IDX_PICSTART: rd_mux = {20'h0, pic_ff};
            `VICR_IDX_LDELAY:   rd_mux = {20'h0, luma_chroma_delay_ff, 6'h00};
            `VICR_IDX_HELPER:   rd_mux = {20'h0, hlp_ff};
            `VICR_IDX_VGA:      rd_mux = {20'h0, vga_ff[11], 8'h0,
                                          vga_ff[2:0]};
            `VICR_IDX_IRQ_STAT: rd_mux = {30'h0, stat_ff};
            `VICR_IDX_IRQ_MASK: rd_mux = {30'h0, mask_ff};
            default:            rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_ff) begin
            avs_readdata <= rd_mux;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_input_source_select_wr;
        wr_input_source_select;
    endsequence

    sequence s_reinit_pulse;
        std_reinit ##1 !std_reinit || wr_input_source_select;
    endsequence

    property p_reinit;
        @(posedge ref_clk) disable iff (reset)
        s_input_source_select_wr |=> s_reinit_pulse;
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("input select write gave no re-init");

    property p_luma_route;
        @(posedge ref_clk) disable iff (reset)
        (luma_code == 2'h0) |-> (luma_input_sel == 4'h4);
    endproperty
    a_luma_route: assert property (p_luma_route)
        else $error("luma code 0 not routed to input three");

    property p_ifc_secam;
        @(posedge ref_clk) disable iff (reset)
        (ifc_code == 2'h3 && !std_is_secam) |-> (if_comp_mode == 2'h0);
    endproperty
    a_ifc_secam: assert property (p_ifc_secam)
        else $error("secam-only compensation used outside secam");

    property p_pic_hold;
        @(posedge ref_clk) disable iff (reset)
        !pic_apply |=> $stable(picture_start);
    endproperty
    a_pic_hold: assert property (p_pic_hold)
        else $error("picture start changed without update");

    property p_done_set;
        @(posedge ref_clk) disable iff (reset)
        input_source_select_done |=> input_source_select_ff[`VICR_DONE_BIT] && stat_ff[0];
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("completion bit not set");

    property p_vga_force;
        @(posedge ref_clk) disable iff (reset)
        !pc_mode_en && !wr_vga |=> vga_line_freq_sel == 3'h1;
    endproperty
    a_vga_force: assert property (p_vga_force)
        else $error("line frequency not forced while vga off");

    property p_hlp_span;
        @(posedge ref_clk) disable iff (reset)
        !helper_mode || !helper_delay[11] ||
        (12'h000 - helper_delay) <= `VICR_HLP_LIMIT;
    endproperty
    a_hlp_span: assert property (p_hlp_span)
        else $error("helper delay below span");

    property p_reset_vals;
        @(posedge ref_clk)
        $past(reset) |-> input_source_select_ff == `VICR_RST_INPUT_SOURCE_SELECT && vga_ff == 12'h000;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("defaults not taken at reset");

    property p_luma_chroma_delay_apply;
        @(posedge ref_clk) disable iff (reset)
        std_apply |=> luma_delay == $past(luma_chroma_delay_ff);
    endproperty
    a_luma_chroma_delay_apply: assert property (p_luma_chroma_delay_apply)
        else $error("luma delay not applied on update");

endmodule
`default_nettype wire

// *** sim/tb_vicr_regs.sv ***
// self-checking bench for the video input config register bank
`timescale 1ns/10ps
`default_nettype none
module tb_vicr_regs import vicr_pkg::*;;
    // ************************************************************
    // stimulus, outputs and model state
    // ************************************************************
    logic            ref_clk       = 1'b0;
    logic            reset         = 1'b1;
    logic [9:0]      avs_address   = 10'h000;
    logic            avs_read      = 1'b0;
    logic            avs_write     = 1'b0;
    logic [31:0]     avs_writedata = 32'h00000000;
    logic [3:0]      ev            = 4'h0;
    logic            std_is_secam  = 1'b0;
    logic            helper_mode   = 1'b0;
    wire [31:0]      avs_readdata;
    wire             avs_waitrequest;
    wire             std_reinit;
    wire [3:0]       luma_input_sel;
    wire             chroma_from_cin;
    wire [1:0]       if_comp_mode;
    vicr_chroma_bw_t chroma_bw;
    wire             fixed_notch;
    wire             luma_lowpass_en;
    vicr_pll_speed_t line_pll_speed;
    wire [11:0]      picture_start;
    wire [5:0]       luma_delay;
    wire [11:0]      helper_delay;
    wire [2:0]       vga_line_freq_sel;
    wire             pc_mode_en;
    wire             irq;
    integer          fail_count = 0;
    integer          n_checks   = 0;
    integer          seed       = 63;
    integer          i;
    integer          m_input_source_select    = 32'h00000644;
    integer          m_pic      = 32'h0;
    integer          m_pic_act  = 32'h0;
    integer          m_luma_chroma_delay     = 32'h0;
    integer          m_luma_chroma_delay_act = 32'h0;
    integer          m_hlp      = 32'h0;
    integer          m_vga      = 32'h0;
    integer          m_stat     = 32'h0;
    integer          m_mask     = 32'h0;
    logic [3:0]      lut_luma [4] = '{4'h4, 4'h2, 4'h1, 4'h8};
    logic [2:0]      lut_vga [4]  = '{3'h1, 3'h2, 3'h4, 3'h4};
    logic [11:0]     hlp_tab [6]  = '{12'h050, 12'h7ff, 12'h800,
                                      12'hfb0, 12'h060, 12'hf9f};

    always #5 ref_clk = ~ref_clk;

    vicr_regs i_vicr_regs (
        .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .std_update(ev[0]),
        .scaler_mode_wr(ev[1]), .input_source_select_done(ev[2]), .vga_done(ev[3]),
        .std_is_secam(std_is_secam), .helper_mode(helper_mode),
        .std_reinit(std_reinit), .luma_input_sel(luma_input_sel),
        .chroma_from_cin(chroma_from_cin), .if_comp_mode(if_comp_mode),
        .chroma_bw(chroma_bw), .fixed_notch(fixed_notch),
        .luma_lowpass_en(luma_lowpass_en), .line_pll_speed(line_pll_speed),
        .picture_start(picture_start), .luma_delay(luma_delay),
        .helper_delay(helper_delay), .vga_line_freq_sel(vga_line_freq_sel),
        .pc_mode_en(pc_mode_en), .irq(irq)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string what);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask

    // slave stalls one cycle, so wait on the handshake, giving up after 20 clocks
    task automatic wait_ack();
        integer n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) chk(32'h1, 32'h0, "waitrequest stuck");
    endtask

    task automatic model_wr(input logic [9:0] a, input logic [31:0] d);
        case (a)
            10'h084: begin
                m_input_source_select    = d[11:0];
                m_pic_act  = m_pic;
                m_luma_chroma_delay_act = m_luma_chroma_delay;
            end
            10'h088: m_pic = d[11:0];
            10'h08c: m_luma_chroma_delay = d[11:0] & 12'hfc0;
            10'h0a4: m_hlp = d[11:0];
            10'h0bc: m_vga = d[2] ? d[11:0] : d[11:0] & 12'hffc;
            10'h0c0: m_stat = m_stat & ~d[1:0];
            10'h0c4: m_mask = d[1:0];
            default: ;
        endcase
    endtask

    task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
        logic ri;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        wait_ack();
        avs_write     <= 1'b0;
        #1 ri = std_reinit;
        chk({31'h0, ri}, {31'h0, a == 10'h084}, "reinit");
        model_wr(a, d);
        @(posedge ref_clk);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_ack();
        chk(avs_readdata, e, "readdata");
        avs_read    <= 1'b0;
        @(posedge ref_clk);
    endtask

    // ev bits: std update, scaler write, input_source_select done, vga done
    task automatic pulse_ev(input logic [3:0] m);
        ev <= m;
        @(posedge ref_clk);
        ev <= 4'h0;
        if (m[0] || m[1]) m_pic_act = m_pic;
        if (m[0]) m_luma_chroma_delay_act = m_luma_chroma_delay;
        if (m[2]) m_input_source_select = m_input_source_select | 12'h800;
        if (m[3]) m_vga = m_vga | 12'h800;
        m_stat = m_stat | m[3:2];
        @(posedge ref_clk);
    endtask

    task automatic rd_all();
        rd_chk(10'h084, m_input_source_select);
        rd_chk(10'h088, m_pic);
        rd_chk(10'h08c, m_luma_chroma_delay);
        rd_chk(10'h0a4, m_hlp);
        rd_chk(10'h0bc, m_vga);
        rd_chk(10'h0c0, m_stat);
        rd_chk(10'h0c4, m_mask);
    endtask

    task automatic check_outs();
        integer      s;
        logic [11:0] hd;
        logic [1:0]  if_comp_field;
        #1;
        s   = m_hlp[11] ? m_hlp - 4096 : m_hlp;
        s   = s > 96 ? 96 : (s < -96 ? -96 : s);
        hd  = helper_mode ? s[11:0] : 12'h000;
        if_comp_field = (m_input_source_select[4:3] == 2'h3 && !std_is_secam) ? 2'h0 : m_input_source_select[4:3];
        chk(luma_input_sel, lut_luma[m_input_source_select[1:0]], "luma");
        chk(chroma_from_cin, m_input_source_select[2], "chroma");
        chk(if_comp_mode, if_comp_field, "ifc");
        chk(chroma_bw, m_input_source_select[6:5], "bw");
        chk({luma_lowpass_en, fixed_notch}, m_input_source_select[8:7], "filt");
        chk(line_pll_speed, m_input_source_select[10:9], "pll");
        chk(picture_start, m_pic_act, "pic");
        chk(luma_delay, m_luma_chroma_delay_act[11:6], "luma_chroma_delay");
        chk(helper_delay, hd, "helper");
        chk(vga_line_freq_sel, lut_vga[m_vga[1:0]], "vga f");
        chk(pc_mode_en, m_vga[2], "vga en");
        chk(irq, |(m_stat & m_mask), "irq");
        @(posedge ref_clk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ************************************************************
    // watchdog and main sequence
    // ************************************************************
    // whole run is well under 2000 cycles
    initial begin
        #100000;
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd_all();
        check_outs();
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            std_is_secam <= i[2];
            bus_wr(10'h084, {1'b0, i[1:0], i[0], i[1], i[1:0], i[1:0],
                             i[0], i[1:0]});
            check_outs();
        end
        // software keeps bit 11 zero, upper bus bits are noise
        for (i = 0; i < 16; i++) begin
            std_is_secam <= $random(seed);
            bus_wr(10'h084, $random(seed) & 32'hfffff7ff);
            check_outs();
        end
        $display("test input select done");
        bus_wr(10'h088, 32'h123);
        bus_wr(10'h08c, 32'h540);
        check_outs();
        pulse_ev(4'h2);
        check_outs();
        bus_wr(10'h088, 32'habc);
        bus_wr(10'h08c, 32'hfc0);
        pulse_ev(4'h1);
        check_outs();
        rd_all();
        $display("test delays done");
        for (i = 0; i < 10; i++) begin
            helper_mode <= (i < 8);
            bus_wr(10'h0a4, i < 6 ? hlp_tab[i] : $random(seed));
            check_outs();
        end
        $display("test helper done");
        for (i = 0; i < 5; i++) begin
            bus_wr(10'h0bc, i < 4 ? 32'h4 | i : 32'h3);
            check_outs();
            rd_chk(10'h0bc, m_vga);
        end
        // enabling write from the disabled state keeps its frequency code
        bus_wr(10'h0bc, 32'h6);
        check_outs();
        $display("test vga done");
        pulse_ev(4'h4);
        check_outs();
        bus_wr(10'h0c4, 32'h3);
        check_outs();
        pulse_ev(4'h8);
        rd_all();
        bus_wr(10'h0c0, 32'h1);
        check_outs();
        bus_wr(10'h0c0, 32'h2);
        check_outs();
        bus_wr(10'h084, m_input_source_select & 32'h7ff);
        rd_all();
        $display("test events done");
        bus_wr(10'h100, 32'hffffffff);
        rd_chk(10'h100, 32'h0);
        rd_all();
        check_outs();
        $display("test unmapped done");
        report_and_stop();
    end
endmodule
`default_nettype wire
